// ===== ssq_pkg.sv
package ssq_pkg;

  // ****************************************
  // widths and positions
  // ****************************************
  localparam int         RES_BITS   = 8;
  localparam logic [2:0] MSB_IDX    = 3'h7;
  localparam int         START_POS  = 2;
  localparam int         SGL_POS    = 1;
  localparam int         PAR_POS    = 0;
  localparam int         FIFO_DEPTH = 32;
  localparam logic [7:0] TRIAL_INIT = 8'h80;

  // ****************************************
  // timing
  // ****************************************
  localparam int CONV_TIME_NS = 32000;
  localparam int SCLK_KHZ     = 250;
  localparam int CONV_CLOCKS  = CONV_TIME_NS * SCLK_KHZ / 1000000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SSQ_ADDR   = 3'b000,
    SSQ_SETTLE = 3'b001,
    SSQ_MSB    = 3'b010,
    SSQ_LSB    = 3'b011,
    SSQ_DONE   = 3'b100
  } ssq_state_e;

  typedef struct packed {
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
  } ssq_mux_s;

  typedef struct packed {
    ssq_mux_s             mux;
    logic [RES_BITS-1:0]  code;
  } ssq_result_s;

  typedef struct packed {
    logic                cs_s1;
    logic                cs_s2;
    logic                ck_s1;
    logic                ck_s2;
    logic                ck_s3;
    logic                din_s1;
    logic                din_s2;
    logic                cmp_s1;
    logic                cmp_s2;
    ssq_state_e          st;
    logic [2:0]          sr;
    logic [2:0]          bitcnt;
    logic [RES_BITS-1:0] result;
    logic [RES_BITS-1:0] trial;
    logic                dout;
    logic                doe_n;
    ssq_mux_s            mux;
    logic                push;
  } ssq_seq_s;

  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam ssq_mux_s MUX_FIXED = '{a_pos: 1'b1, a_neg: 1'b0, b_pos: 1'b0, b_neg: 1'b1};
  localparam ssq_mux_s MUX_NONE  = '{a_pos: 1'b0, a_neg: 1'b0, b_pos: 1'b0, b_neg: 1'b0};

  localparam ssq_seq_s SEQ_RST = '{
    cs_s1: 1'b1, cs_s2: 1'b1, ck_s1: 1'b0, ck_s2: 1'b0, ck_s3: 1'b0,
    din_s1: 1'b0, din_s2: 1'b0, cmp_s1: 1'b0, cmp_s2: 1'b0,
    st: SSQ_ADDR, sr: 3'h0, bitcnt: 3'h0, result: 8'h00, trial: 8'h00,
    dout: 1'b0, doe_n: 1'b1, mux: MUX_NONE, push: 1'b0
  };

endpackage

// ===== ssq_sequencer.sv
`timescale 1ns/1ps

module ssq_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ssq_ptr_s;

  ssq_ptr_s         q;
  ssq_ptr_s         nxt_q;
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic             full;
  logic             empty;

  assign empty     = (q.wr == q.rd);
  assign full      = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_ff[q.rd[AW-1:0]];

  always_comb begin
    nxt_q = q;
    if (in_valid && !full) begin
      nxt_q.wr = q.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_q.rd = q.rd + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= nxt_q;
    end
  end

  // storage needs no reset; only written slots are ever read
  always_ff @(posedge sys_clk) begin
    if (in_valid && !full) begin
      mem_ff[q.wr[AW-1:0]] <= in_data;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_fifo_no_overrun : assert property (full |=> q.wr == $past(q.wr))
    else $error("fifo written while full");

endmodule // ssq_fifo

module ssq_sequencer #(
  parameter bit TWIN  = 1'b1,
  parameter int DEPTH = ssq_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  // serial pins from the host
  input  wire logic                 sel_n_pin,
  input  wire logic                 sclk_pin,
  input  wire logic                 serial_in_line,
  output logic                      serial_out,
  output logic                      serial_out_oe_n,
  // analog front end
  input  wire logic                 comp_high,
  output logic [7:0]                dac_code,
  output ssq_pkg::ssq_mux_s         mux_sel,
  // result stream
  output logic                      res_valid,
  input  wire logic                 res_ready,
  output ssq_pkg::ssq_result_s      res_data
);

  import ssq_pkg::*;

  // ****************************************
  // state
  // ****************************************
  ssq_seq_s    q;
  ssq_seq_s    nxt_q;
  logic        sck_rise;
  logic        sck_fall;
  logic        fifo_in_ready;
  ssq_result_s push_data;

  assign sck_rise = q.ck_s2 && !q.ck_s3;
  assign sck_fall = !q.ck_s2 && q.ck_s3;

  function automatic ssq_mux_s mux_decode(input logic sgl, input logic par);
    ssq_mux_s m;
    m = MUX_NONE;
    m.a_pos = !par;
    m.b_pos = par;
    if (!sgl) begin
      m.a_neg = par;
      m.b_neg = !par;
    end
    return m;
  endfunction

  // ****************************************
  // sequencer
  // ****************************************
  always_comb begin
    logic [2:0] idx;
    idx          = MSB_IDX - q.bitcnt;
    nxt_q        = q;
    nxt_q.cs_s1  = sel_n_pin;
    nxt_q.cs_s2  = q.cs_s1;
    nxt_q.ck_s1  = sclk_pin;
    nxt_q.ck_s2  = q.ck_s1;
    nxt_q.ck_s3  = q.ck_s2;
    nxt_q.din_s1 = serial_in_line;
    nxt_q.din_s2 = q.din_s1;
    nxt_q.cmp_s1 = comp_high;
    nxt_q.cmp_s2 = q.cmp_s1;
    nxt_q.push   = 1'b0;
    if (q.cs_s2) begin
      nxt_q.st     = SSQ_ADDR;
      nxt_q.sr     = 3'h0;
      nxt_q.bitcnt = 3'h0;
      nxt_q.result = 8'h00;
      nxt_q.trial  = 8'h00;
      nxt_q.dout   = 1'b0;
      nxt_q.doe_n  = 1'b1;
      nxt_q.mux    = MUX_NONE;
    end else begin
      unique case (q.st)
        SSQ_ADDR: begin
          // a full result queue holds off the start
          // shift only while addressing
          if (sck_rise && fifo_in_ready) begin
            nxt_q.sr = {q.sr[1:0], q.din_s2};
            if (!TWIN) begin
              nxt_q.mux = MUX_FIXED;
              nxt_q.st  = SSQ_SETTLE;
            end else if (nxt_q.sr[START_POS]) begin
              nxt_q.mux = mux_decode(nxt_q.sr[SGL_POS], nxt_q.sr[PAR_POS]);
              nxt_q.st  = SSQ_SETTLE;
            end
          end
        end
        SSQ_SETTLE: begin
          if (sck_fall) begin
            nxt_q.doe_n  = 1'b0;
            nxt_q.dout   = 1'b0;
            nxt_q.trial  = TRIAL_INIT;
            nxt_q.bitcnt = 3'h0;
            nxt_q.st     = SSQ_MSB;
          end
        end
        SSQ_MSB: begin
          if (sck_fall) begin
            nxt_q.result[idx] = q.cmp_s2;
            nxt_q.trial[idx]  = q.cmp_s2;
            if (idx != 3'h0) begin
              nxt_q.trial[idx-3'h1] = 1'b1;
            end
            nxt_q.dout   = q.cmp_s2;
            nxt_q.bitcnt = q.bitcnt + 3'h1;
            // eight periods at the rated clock
            if (q.bitcnt == 3'(CONV_CLOCKS - 1)) begin
              nxt_q.push   = 1'b1;
              nxt_q.bitcnt = 3'h1;
              nxt_q.st     = TWIN ? SSQ_LSB : SSQ_DONE;
            end
          end
        end
        SSQ_LSB: begin
          if (sck_fall) begin
            nxt_q.dout   = q.result[q.bitcnt];
            nxt_q.bitcnt = q.bitcnt + 3'h1;
            if (q.bitcnt == MSB_IDX) begin
              nxt_q.st = SSQ_DONE;
            end
          end
        end
        SSQ_DONE: begin
          if (sck_fall) begin
            nxt_q.dout = 1'b0;
          end
        end
        default: begin
          nxt_q.st = SSQ_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= SEQ_RST;
    end else begin
      q <= nxt_q;
    end
  end

  // ****************************************
  // outputs and result queue
  // ****************************************
  assign serial_out      = q.dout;
  assign serial_out_oe_n = q.doe_n;
  assign dac_code        = q.trial;
  assign mux_sel         = q.mux;
  assign push_data       = '{mux: q.mux, code: q.result};

  ssq_fifo #(
    .WIDTH ($bits(ssq_result_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (q.push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_addr_released : assert property (q.st == SSQ_ADDR |-> serial_out_oe_n)
    else $error("output driven during addressing");

  a_deselect_clears : assert property (q.cs_s2 |=> q.st == SSQ_ADDR && serial_out_oe_n && q.result == 8'h00)
    else $error("deselect did not clear");

  a_settle_low : assert property (q.st == SSQ_SETTLE && sck_fall && !q.cs_s2
    |=> !serial_out && !serial_out_oe_n && q.st == SSQ_MSB)
    else $error("settling period not driven low");

  a_msb_bit_out : assert property (q.st == SSQ_MSB && sck_fall && !q.cs_s2
    |=> serial_out == $past(q.cmp_s2))
    else $error("decided bit not shifted out");

  a_push_after_eight : assert property (q.push |-> $past(q.bitcnt) == MSB_IDX && $past(q.st) == SSQ_MSB)
    else $error("result pushed at wrong count");

  a_input_ignored : assert property (q.st != SSQ_ADDR && !q.cs_s2 |=> $stable(q.sr))
    else $error("serial input taken during conversion");

  a_one_positive : assert property (q.st != SSQ_ADDR |-> $onehot({q.mux.a_pos, q.mux.b_pos}))
    else $error("channel decode illegal");

  a_done_quiet : assert property (q.st == SSQ_DONE && sck_fall |=> !serial_out)
    else $error("output not quiet after last bit");

  a_addr_shift : assert property (q.st == SSQ_ADDR && sck_rise && fifo_in_ready && !q.cs_s2
    |=> q.sr == {$past(q.sr[1:0]), $past(q.din_s2)})
    else $error("address bit not captured");

  a_lsb_order : assert property (q.st == SSQ_LSB && sck_fall && !q.cs_s2
    |=> serial_out == $past(q.result[q.bitcnt]))
    else $error("lsb-first bit wrong");

  a_fall_only : assert property (!sck_fall && !q.cs_s2 |=> $stable(serial_out))
    else $error("output moved off a falling edge");

endmodule // ssq_sequencer

// ===== ssq_host_model.sv
`timescale 1ns/1ps

module ssq_host_model #(
  // address periods: start bit plus any assignment word
  parameter int ABITS = 3
) (
  // clock
  input  wire logic       sys_clk,
  // bench control
  input  wire logic       go,
  input  wire logic [1:0] cfg,
  input  wire logic [4:0] nper,
  input  wire logic [7:0] vin,
  input  wire logic       neg_high,
  output logic            busy,
  output logic [16:0]     rx,
  output logic [16:0]     rx_oe_n,
  // pins
  output logic            sel_n_pin,
  output logic            sclk_pin,
  output logic            serial_in_line,
  input  wire logic       serial_out,
  input  wire logic       serial_out_oe_n,
  input  wire logic [7:0] dac_code,
  output logic            comp_high
);
  // ****
  // analog side
  // ****
  // negative side higher
  // half step offset: code equals vin either way
  assign comp_high = !neg_high && ({vin, 1'b1} > {dac_code, 1'b0});

  // ****
  // host sequence
  // ****
  task automatic half();
    repeat (8) @(negedge sys_clk);
  endtask

  initial begin
    sel_n_pin = 1'b1;
    sclk_pin = 1'b0;
    serial_in_line = 1'b0;
    busy = 1'b0;
    rx = '0;
    rx_oe_n = '0;
    forever begin
      @(negedge sys_clk);
      if (go) begin
        busy = 1'b1;
        sel_n_pin = 1'b0;
        for (int k = 0; k < nper + ABITS; k++) begin
          if (k < ABITS)
            serial_in_line = (k == 0) ? 1'b1 : cfg[2-k];
          else
            serial_in_line = !serial_in_line;
          half();
          sclk_pin = 1'b1;
          if (k >= ABITS) begin
            // released line reads back as the inverse
            rx[k-ABITS] = serial_out_oe_n ? !serial_out : serial_out;
            rx_oe_n[k-ABITS] = serial_out_oe_n;
          end
          half();
          sclk_pin = 1'b0;
        end
        half();
        sel_n_pin = 1'b1;
        half();
        busy = 1'b0;
      end
    end
  end
endmodule // ssq_host_model

// ===== serial_sar_adc_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    failures++; \
    $display("BAD %0t mismatch", $time); \
  end \
end

module serial_sar_adc_sequencer_bench;
  import ssq_pkg::*;
  logic        sys_clk, reset, go, neg_high, res_ready, busy, comp_high;
  logic        sel_n_pin, sclk_pin, serial_in_line, serial_out, serial_out_oe_n, res_valid;
  logic [1:0]  cfg;
  logic [4:0]  nper;
  logic [7:0]  vin, dac_code;
  logic [16:0] rx, rx_oe_n;
  ssq_mux_s    mux_sel;
  ssq_result_s res_data;
  logic        go1, busy1, sel_n1, sclk1, sin1, sout1, soe1_n, comp1, valid1, ready1;
  logic [7:0]  dac1;
  logic [16:0] rx1, rx1_oe_n;
  ssq_mux_s    mux1;
  ssq_result_s data1;
  int          failures, checks_done;
  logic [7:0]  tv [4] = '{8'hA5, 8'h00, 8'hFF, 8'h5A};

  ssq_sequencer #(.TWIN(1'b1), .DEPTH(FIFO_DEPTH)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
    .serial_in_line(serial_in_line), .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .comp_high(comp_high), .dac_code(dac_code), .mux_sel(mux_sel),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

  ssq_host_model u_host (
    .sys_clk(sys_clk), .go(go), .cfg(cfg), .nper(nper), .vin(vin), .neg_high(neg_high),
    .busy(busy), .rx(rx), .rx_oe_n(rx_oe_n), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
    .serial_in_line(serial_in_line), .serial_out(serial_out),
    .serial_out_oe_n(serial_out_oe_n), .dac_code(dac_code), .comp_high(comp_high));

  // single variant: fixed pair, one address period for the start bit, no assignment word
  ssq_sequencer #(.TWIN(1'b0), .DEPTH(FIFO_DEPTH)) u_dut_single (
    .sys_clk(sys_clk), .reset(reset), .sel_n_pin(sel_n1), .sclk_pin(sclk1),
    .serial_in_line(sin1), .serial_out(sout1), .serial_out_oe_n(soe1_n),
    .comp_high(comp1), .dac_code(dac1), .mux_sel(mux1),
    .res_valid(valid1), .res_ready(ready1), .res_data(data1));

  ssq_host_model #(.ABITS(1)) u_host_single (
    .sys_clk(sys_clk), .go(go1), .cfg(cfg), .nper(nper), .vin(vin), .neg_high(neg_high),
    .busy(busy1), .rx(rx1), .rx_oe_n(rx1_oe_n), .sel_n_pin(sel_n1), .sclk_pin(sclk1),
    .serial_in_line(sin1), .serial_out(sout1),
    .serial_out_oe_n(soe1_n), .dac_code(dac1), .comp_high(comp1));

  // ****
  // helpers
  // ****
  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic run(input logic [1:0] c, input logic [4:0] n, input logic [7:0] v, input logic ng,
                     input bit one = 1'b0);
    cfg <= c;
    nper <= n;
    vin <= v;
    neg_high <= ng;
    if (one)
      go1 <= 1'b1;
    else
      go <= 1'b1;
    @(negedge sys_clk);
    go <= 1'b0;
    go1 <= 1'b0;
    repeat (2) @(negedge sys_clk);
    for (int i = 0; busy || busy1; i++) begin
      if (i > 2000) begin
        failures++;
        $display("BAD %0t host never finished", $time);
        results();
      end
      @(negedge sys_clk);
    end
  endtask

  // settle low, msb first, then bits 1..7, then quiet
  function automatic logic [16:0] bits(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = v[7-i];
    return {1'b0, v[7:1], r, 1'b0};
  endfunction

  function automatic ssq_mux_s mexp(input logic [1:0] c);
    case (c)
      2'h0: return ssq_mux_s'(4'h9);
      2'h1: return ssq_mux_s'(4'h6);
      2'h2: return ssq_mux_s'(4'h8);
      default: return ssq_mux_s'(4'h2);
    endcase
  endfunction

  task automatic take(input logic [1:0] c, input logic [7:0] v);
    for (int i = 0; res_valid !== 1'b1; i++) begin
      if (i > 50) begin
        failures++;
        $display("BAD %0t no result queued", $time);
        results();
      end
      @(negedge sys_clk);
    end
    `CHK(res_data.code, v)
    `CHK(res_data.mux, mexp(c))
    res_ready <= 1'b1;
    @(negedge sys_clk);
    res_ready <= 1'b0;
    @(negedge sys_clk);
  endtask

  // ****
  // scenarios
  // ****
  task automatic t_reset();
    `CHK(serial_out, 1'b0)
    `CHK(serial_out_oe_n, 1'b1)
    `CHK(dac_code, 8'h00)
    `CHK(mux_sel, MUX_NONE)
    `CHK(res_valid, 1'b0)
  endtask

  task automatic t_conv();
    for (int c = 0; c < 4; c++) begin
      run(c[1:0], 5'h11, tv[c], 1'b0);
      `CHK(rx[8:0], bits(tv[c]) & 17'h001FF)
      `CHK(rx[15:9], tv[c][7:1])
      `CHK(rx[16], 1'b0)
      `CHK(rx_oe_n, 17'h00000)
      `CHK(serial_out_oe_n, 1'b1)
      take(c[1:0], tv[c]);
    end
  endtask

  task automatic t_zero();
    run(2'h0, 5'h11, 8'hFF, 1'b1);
    `CHK(rx, 17'h00000)
    take(2'h0, 8'h00);
  endtask

  // deselect after three result bits
  task automatic t_abort();
    run(2'h3, 5'h04, 8'hA5, 1'b0);
    `CHK(rx[3:0], 4'hA)
    `CHK(dac_code, 8'h00)
    `CHK(mux_sel, MUX_NONE)
    `CHK(serial_out_oe_n, 1'b1)
    `CHK(res_valid, 1'b0)
  endtask

  // single variant ignores the word and has no lsb-first repeat
  task automatic t_single();
    run(2'h3, 5'h11, 8'hA5, 1'b0, 1'b1);
    `CHK(rx1[8:0], bits(8'hA5) & 17'h001FF)
    `CHK(rx1[16:9], 8'h00)
    `CHK(rx1_oe_n, 17'h00000)
    `CHK(mux1, MUX_NONE)
    for (int i = 0; valid1 !== 1'b1; i++) begin
      if (i > 50) begin
        failures++;
        $display("BAD %0t no single result", $time);
        results();
      end
      @(negedge sys_clk);
    end
    `CHK(data1.code, 8'hA5)
    `CHK(data1.mux, mexp(2'h0))
    ready1 <= 1'b1;
    @(negedge sys_clk);
    ready1 <= 1'b0;
    @(negedge sys_clk);
    `CHK(valid1, 1'b0)
  endtask

  // consumer stalls until the fifo refuses a start
  task automatic t_fill();
    for (int i = 0; i < FIFO_DEPTH; i++)
      run(i[1:0], 5'h11, i[7:0] * 8'h07, 1'b0);
    run(2'h0, 5'h11, 8'h33, 1'b0);
    `CHK(rx_oe_n, 17'h1FFFF)
    for (int i = 0; i < FIFO_DEPTH; i++)
      take(i[1:0], i[7:0] * 8'h07);
    `CHK(res_valid, 1'b0)
  endtask

  // ****
  // clock and main sequence
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    reset = 1'b1;
    go = 1'b0;
    go1 = 1'b0;
    ready1 = 1'b0;
    cfg = 2'h0;
    nper = 5'h00;
    vin = 8'h00;
    neg_high = 1'b0;
    res_ready = 1'b0;
    failures = 0;
    checks_done = 0;
    repeat (16) @(negedge sys_clk);
    reset = 1'b0;
    repeat (8) @(negedge sys_clk);
    t_reset();
    t_conv();
    t_zero();
    t_abort();
    t_single();
    t_conv();
    t_fill();
    results();
  end
endmodule // serial_sar_adc_sequencer_bench
